/* File: hdl/smps_pkg.sv */
// Constants, timing counts and state type of the ship mode power sequencer
package smps_pkg;
    // Clock rate in kHz
    localparam int unsigned CLK_KHZ = 40000;
    // Tick divider: 1 ms tick from 40 MHz
    localparam int unsigned TICK_CYC = CLK_KHZ;
    // Times in ms
    localparam int unsigned WAKE_MIN_MS = 80;
    localparam int unsigned WAKE_MAX_MS = 1000;
    localparam int unsigned RESET_MIN_MS = 5000;
    localparam int unsigned RESET_MAX_MS = 15000;
    localparam int unsigned WDOG_MS = 50000;
    localparam int unsigned IDLE_MS = 700;
    localparam int unsigned HIZ_ACT_MS = 1;
    localparam int unsigned QUIET_MS = 1;
    localparam int unsigned SW_START_MS = 5;
    localparam int unsigned SW_START_MAX_MS = 25;
    // Times in us, and their cycle counts
    localparam int unsigned SYS_START_US = 350;
    localparam int unsigned SYS_START_CYC = SYS_START_US * CLK_KHZ / 1000;
    localparam int unsigned RST_DD_US = 6;
    localparam int unsigned RST_DD_CYC = RST_DD_US * CLK_KHZ / 1000;
    // Width of ms counters
    localparam int unsigned MS_W = 17;
    // Sequencer states
    typedef enum logic [2:0] {
        SMPS_ACTIVE,
        SMPS_QUIET,
        SMPS_SHIP,
        SMPS_WAKE
    } smps_state_t;
endpackage : smps_pkg

/* File: hdl/smps_seq.sv */
// Ship mode entry and exit sequencer with push-button and start-up timers
`timescale 1ns/1ps
`default_nettype none
module smps_seq #(
    parameter int unsigned TICK_CYC = smps_pkg::TICK_CYC,
    parameter int unsigned SYS_CYC = smps_pkg::SYS_START_CYC,
    parameter int unsigned WDOG_MS = smps_pkg::WDOG_MS,
    parameter int unsigned IDLE_MS = smps_pkg::IDLE_MS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    // Input supply above lockout level
    input wire logic input_valid_i,
    // Input above battery plus sleep margin
    input wire logic input_above_bat_i,
    // Battery above highest undervoltage level
    input wire logic bat_above_max_uv_i,
    // Push-button, low when pressed
    input wire logic pushbutton_input_n_i,
    // Charge-disable pin level
    input wire logic charge_disable_pin_n_i,
    // Ship entry request bit from host
    input wire logic ship_entry_request_bit_i,
    // Long press action select bit
    input wire logic long_press_action_select_i,
    // Wake hold time in ms
    input wire logic [16:0] wake_ms_i,
    // Reset hold time in ms, zero for a fast reset after RST_DD_CYC cycles
    input wire logic [16:0] reset_ms_i,
    // Switching output enable written
    input wire logic switching_output_enable_i,
    // Host bus activity pulse and transfer in progress
    input wire logic bus_activity_i,
    input wire logic bus_busy_i,
    output logic ship_mode_o,
    output logic mid_supply_node_on_o,
    output logic bus_ready_o,
    output logic bus_reset_o,
    output logic reset_out_o,
    output logic active_battery_o,
    output logic sys_start_o,
    output logic sw_start_o
);
    import smps_pkg::*;

    // Registers
    smps_state_t state_reg, state_next;
    logic [31:0] div_reg, div_next;
    logic tick;
    logic [16:0] press_reg, press_next;
    logic [16:0] seq_reg, seq_next;
    logic [16:0] wd_reg, wd_next;
    logic [16:0] idle_reg, idle_next;
    logic [16:0] rdy_reg, rdy_next;
    logic [16:0] sw_reg, sw_next;
    logic [31:0] sys_reg, sys_next;
    logic [7:0] dd_reg, dd_next;
    logic pend_reg, pend_next;
    logic arm_reg, arm_next;
    logic armwin_reg, armwin_next;
    logic [16:0] armcnt_reg, armcnt_next;
    logic vin_d_reg, vin_d_next;
    logic long_reg, long_next;
    logic bus_rst_reg, bus_rst_next;
    logic rst_reg, rst_next;
    logic ready_reg, ready_next;
    logic act_d_reg, act_d_next;
    logic conds;
    logic pressed;

    // Combined entry conditions
    // three entry conditions
    assign conds = !input_valid_i && charge_disable_pin_n_i
        && pushbutton_input_n_i;
    assign pressed = !pushbutton_input_n_i;
    assign tick = (div_reg == 32'(TICK_CYC - 1));

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        div_next = tick ? 32'h0 : div_reg + 32'h1;
        press_next = press_reg;
        seq_next = seq_reg;
        wd_next = wd_reg;
        idle_next = idle_reg;
        rdy_next = rdy_reg;
        sw_next = sw_reg;
        sys_next = sys_reg;
        dd_next = dd_reg;
        pend_next = pend_reg;
        arm_next = arm_reg;
        armwin_next = armwin_reg;
        armcnt_next = armcnt_reg;
        vin_d_next = input_valid_i;
        long_next = long_reg;
        bus_rst_next = 1'b0;
        rst_next = rst_reg;
        ready_next = ready_reg;
        act_d_next = act_d_reg;
        if (!pressed) begin
            press_next = 17'h0;
            long_next = 1'b0;
        end else if (tick && press_reg != 17'h1ffff) begin
            press_next = press_reg + 17'h1;
        end
        if (pressed && press_reg >= reset_ms_i && reset_ms_i != 17'h0) begin
            long_next = 1'b1;
        end
        if (pressed && reset_ms_i == 17'h0) begin
            dd_next = (dd_reg == 8'hff) ? dd_reg : dd_reg + 8'h1;
        end else begin
            dd_next = 8'h0;
        end
        rst_next = long_reg
            || (reset_ms_i == 17'h0 && dd_reg >= 8'(RST_DD_CYC - 1));
        pend_next = ship_entry_request_bit_i;
        // adapter during reset press arms entry
        if (input_valid_i && !vin_d_reg) begin
            arm_next = pressed && long_reg;
            armwin_next = pressed && long_reg;
            armcnt_next = 17'h0;
        end
        // arm lost on long hold after connect
        if (armwin_reg && pressed && tick) begin
            armcnt_next = armcnt_reg + 17'h1;
            if (armcnt_reg >= wake_ms_i) begin
                arm_next = 1'b0;
                armwin_next = 1'b0;
            end
        end else if (armwin_reg && !pressed) begin
            armwin_next = 1'b0;
        end
        unique case (state_reg)
            SMPS_ACTIVE: begin
                if (conds && (pend_reg || arm_reg
                    || (long_reg && !long_press_action_select_i))) begin
                    state_next = SMPS_QUIET;
                    seq_next = 17'h0;
                end
            end
            SMPS_QUIET: begin
                if (!conds || (!pend_reg && !arm_reg
                    && long_press_action_select_i)) begin
                    state_next = SMPS_ACTIVE;
                end else if (tick) begin
                    seq_next = seq_reg + 17'h1;
                    if (seq_reg >= 17'(QUIET_MS - 1)) begin
                        state_next = SMPS_SHIP;
                        arm_next = 1'b0;
                    end
                end
            end
            SMPS_SHIP: begin
                if (input_above_bat_i) begin
                    state_next = SMPS_ACTIVE;
                end else if (pressed && bat_above_max_uv_i) begin
                    state_next = SMPS_WAKE;
                    seq_next = 17'h0;
                end
            end
            SMPS_WAKE: begin
                if (input_above_bat_i) begin
                    state_next = SMPS_ACTIVE;
                end else if (pressed) begin
                    if (tick && seq_reg != 17'h1ffff) begin
                        seq_next = seq_reg + 17'h1;
                    end
                end else if (seq_reg >= wake_ms_i) begin
                    state_next = SMPS_ACTIVE;
                end else begin
                    state_next = SMPS_SHIP;
                end
            end
            default: state_next = SMPS_ACTIVE;
        endcase
        act_d_next = !input_valid_i && charge_disable_pin_n_i
            && state_reg == SMPS_ACTIVE;
        if (!act_d_reg && !input_valid_i) begin
            ready_next = 1'b0;
            rdy_next = 17'h0;
        end else if (!ready_reg) begin
            if (tick) begin
                rdy_next = rdy_reg + 17'h1;
            end
            if (rdy_reg >= 17'(HIZ_ACT_MS - 1) && tick) begin
                ready_next = 1'b1;
            end
        end
        // host waits; bus ready only when awake
        if (state_reg != SMPS_ACTIVE) begin
            ready_next = 1'b0;
        end
        if (bus_activity_i) begin
            wd_next = 17'h0;
        end else if (tick) begin
            wd_next = wd_reg + 17'h1;
            if (wd_reg >= 17'(WDOG_MS - 1)) begin
                wd_next = 17'h0;
                bus_rst_next = 1'b1;
            end
        end
        if (!bus_busy_i || bus_activity_i) begin
            idle_next = 17'h0;
        end else if (tick) begin
            idle_next = idle_reg + 17'h1;
            if (idle_reg >= 17'(IDLE_MS - 1)) begin
                idle_next = 17'h0;
                bus_rst_next = 1'b1;
            end
        end
        if (!switching_output_enable_i) begin
            sw_next = 17'h0;
        end else if (tick && sw_reg < 17'(SW_START_MS)) begin
            sw_next = sw_reg + 17'h1;
        end
        if (!(input_valid_i || bat_above_max_uv_i)
            || state_reg != SMPS_ACTIVE) begin
            sys_next = 32'h0;
        end else if (sys_reg < 32'(SYS_CYC)) begin
            sys_next = sys_reg + 32'h1;
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= SMPS_ACTIVE;
            div_reg <= 32'h0;
            press_reg <= 17'h0;
            seq_reg <= 17'h0;
            wd_reg <= 17'h0;
            idle_reg <= 17'h0;
            rdy_reg <= 17'h0;
            sw_reg <= 17'h0;
            sys_reg <= 32'h0;
            dd_reg <= 8'h0;
            pend_reg <= 1'b0;
            arm_reg <= 1'b0;
            armwin_reg <= 1'b0;
            armcnt_reg <= 17'h0;
            vin_d_reg <= 1'b0;
            long_reg <= 1'b0;
            bus_rst_reg <= 1'b0;
            rst_reg <= 1'b0;
            ready_reg <= 1'b0;
            act_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            press_reg <= press_next;
            seq_reg <= seq_next;
            wd_reg <= wd_next;
            idle_reg <= idle_next;
            rdy_reg <= rdy_next;
            sw_reg <= sw_next;
            sys_reg <= sys_next;
            dd_reg <= dd_next;
            pend_reg <= pend_next;
            arm_reg <= arm_next;
            armwin_reg <= armwin_next;
            armcnt_reg <= armcnt_next;
            vin_d_reg <= vin_d_next;
            long_reg <= long_next;
            bus_rst_reg <= bus_rst_next;
            rst_reg <= rst_next;
            ready_reg <= ready_next;
            act_d_reg <= act_d_next;
        end
    end

    // Outputs from flip-flops
    always_comb begin
        ship_mode_o = (state_reg == SMPS_SHIP);
        mid_supply_node_on_o = (state_reg != SMPS_SHIP);
        bus_ready_o = ready_reg;
        bus_reset_o = bus_rst_reg;
        reset_out_o = rst_reg;
        active_battery_o = act_d_reg;
        sys_start_o = (sys_reg == 32'(SYS_CYC));
        sw_start_o = (sw_reg == 17'(SW_START_MS));
    end

    property p_no_ship_vin;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_reg == SMPS_ACTIVE && input_valid_i) |=> state_reg != SMPS_QUIET;
    endproperty
    a_no_ship_vin: assert property (p_no_ship_vin) else $error("ship with input");
    property p_adapter_exit;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_reg == SMPS_SHIP && input_above_bat_i) |=> state_reg == SMPS_ACTIVE;
    endproperty
    a_adapter_exit: assert property (p_adapter_exit) else $error("no exit");
    property p_bat_block;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_reg == SMPS_SHIP && !bat_above_max_uv_i && !input_above_bat_i)
        |=> state_reg == SMPS_SHIP;
    endproperty
    a_bat_block: assert property (p_bat_block) else $error("weak wake");
    property p_quiet_conds;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_reg == SMPS_QUIET && !conds) |=> state_reg == SMPS_ACTIVE;
    endproperty
    a_quiet_conds: assert property (p_quiet_conds) else $error("cond lost");
    // press in ship powers mid node next cycle
    property p_wake_mid;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_reg == SMPS_SHIP && pressed && bat_above_max_uv_i
        && !input_above_bat_i) |=> mid_supply_node_on_o;
    endproperty
    a_wake_mid: assert property (p_wake_mid) else $error("mid off");
    property p_ship_bus;
        @(posedge clk_i) disable iff (!resetn_i)
        state_reg == SMPS_SHIP |=> !bus_ready_o;
    endproperty
    a_ship_bus: assert property (p_ship_bus) else $error("bus ready");
    property p_cancel;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_reg == SMPS_QUIET && !pend_reg && !arm_reg
        && long_press_action_select_i) |=> state_reg == SMPS_ACTIVE;
    endproperty
    a_cancel: assert property (p_cancel) else $error("no cancel");
    property p_bus_pulse;
        @(posedge clk_i) disable iff (!resetn_i)
        bus_reset_o |=> !bus_reset_o;
    endproperty
    a_bus_pulse: assert property (p_bus_pulse) else $error("long pulse");
    c_ship: cover property (@(posedge clk_i) disable iff (!resetn_i)
        state_reg == SMPS_QUIET ##1 state_reg == SMPS_SHIP);
    c_wake: cover property (@(posedge clk_i) disable iff (!resetn_i)
        state_reg == SMPS_WAKE ##1 state_reg == SMPS_ACTIVE);
    c_rst: cover property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(reset_out_o));
endmodule : smps_seq
`default_nettype wire

/* File: bench/smps_host_model.sv */
// Host and push-button model that sits on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module smps_host_model (
    input wire logic clk_i,
    input wire logic ship_mode_i,
    input wire logic req_i,
    input wire logic press_i,
    input wire logic xfer_i,
    input wire logic busy_i,
    output logic ship_entry_request_bit_o,
    output logic pushbutton_input_n_o,
    output logic bus_activity_o,
    output logic bus_busy_o
);
    // Idle host, button released
    initial begin
        ship_entry_request_bit_o = 1'b0;
        pushbutton_input_n_o = 1'b1;
        bus_activity_o = 1'b0;
        bus_busy_o = 1'b0;
    end

    // Pins move only off the sampling edge and then hold steady
    always @(negedge clk_i) begin
        ship_entry_request_bit_o <= req_i;
        pushbutton_input_n_o <= ~press_i;
        bus_activity_o <= xfer_i & ~ship_mode_i;
        bus_busy_o <= busy_i & ~ship_mode_i;
    end
endmodule : smps_host_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking testbench for the ship mode power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import smps_pkg::*;
    // Shortened ms tick, so 1 ms is 4 cycles
    localparam int unsigned TK = 4;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    // Comparator levels and pins
    logic vin = 1'b1, vab = 1'b0, bat = 1'b1, cd = 1'b1, lps = 1'b1;
    logic swe = 1'b0;
    logic [16:0] wake_ms = 17'h00050;
    logic [16:0] rst_ms = 17'h01388;
    // Wishes handed to the partner model
    logic req = 1'b0, press = 1'b0, xfer = 1'b0, busy = 1'b0;
    // Partner pins and design outputs
    logic sreq, btn_n, act, bbusy;
    logic ship, mid, rdy, brst, rout, abat, system_output_rail, sw;
    int error_cnt = 0, n_compared = 0, cyc = 0, pulses = 0;

    smps_seq #(.TICK_CYC(TK), .SYS_CYC(10), .WDOG_MS(40), .IDLE_MS(5))
        smps_seq_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .input_valid_i(vin),
        .input_above_bat_i(vab), .bat_above_max_uv_i(bat),
        .pushbutton_input_n_i(btn_n), .charge_disable_pin_n_i(cd),
        .ship_entry_request_bit_i(sreq), .long_press_action_select_i(lps),
        .wake_ms_i(wake_ms), .reset_ms_i(rst_ms),
        .switching_output_enable_i(swe), .bus_activity_i(act),
        .bus_busy_i(bbusy), .ship_mode_o(ship), .mid_supply_node_on_o(mid),
        .bus_ready_o(rdy), .bus_reset_o(brst), .reset_out_o(rout),
        .active_battery_o(abat), .sys_start_o(system_output_rail), .sw_start_o(sw));

    smps_host_model smps_host_model_i (
        .clk_i(clk_i), .ship_mode_i(ship), .req_i(req), .press_i(press),
        .xfer_i(xfer), .busy_i(busy), .ship_entry_request_bit_o(sreq),
        .pushbutton_input_n_o(btn_n), .bus_activity_o(act),
        .bus_busy_o(bbusy));

    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Cycle count, interface reset pulses and hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (brst === 1'b1) begin
            pulses++;
        end
        if (cyc == 60000) begin
            error_cnt++;
            finish_test();
        end
    end

    // Verdict and end of run
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Compare one output bit
    task automatic chk(input string nm, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk

    // Pick an output by index
    function automatic logic outv(input int i);
        case (i)
            0: return ship;
            1: return mid;
            2: return rout;
            3: return abat;
            4: return system_output_rail;
            5: return sw;
            default: return rdy;
        endcase
    endfunction : outv

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : idle

    // Bounded wait for an output level, then compare
    task automatic wait_out(input string nm, input int i, input logic exp,
                            input int maxc);
        for (int k = 0; k < maxc && outv(i) !== exp; k++) begin
            @(negedge clk_i);
        end
        chk(nm, exp, outv(i));
    endtask : wait_out

    // Watch for an interface reset pulse over a window
    task automatic pulse_in(input string nm, input int n, input logic exp);
        int p0;
        p0 = pulses;
        idle(n);
        chk(nm, exp, logic'(pulses != p0));
    endtask : pulse_in

    // Hold the button for n cycles
    task automatic hold_btn(input int n);
        press <= 1'b1;
        idle(n);
        press <= 1'b0;
    endtask : hold_btn

    initial begin
        void'($urandom(71816));
        wake_ms = 17'(80 + $urandom % 41);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i <= 1'b1;
        idle(1);
        chk("ship rst", 1'b0, ship); // RESET
        chk("mid rst", 1'b1, mid); // RESET
        chk("rout rst", 1'b0, rout); // RESET
        wait_out("sys", 4, 1'b1, 20);
        // Active battery only with charge pin high and no input
        vin <= 1'b0;
        wait_out("abat", 3, 1'b1, 10);
        cd <= 1'b0;
        wait_out("abat off", 3, 1'b0, 10);
        // High-impedance state keeps the interface off until the pin rises
        idle(2);
        chk("rdy hiz", 1'b0, rdy);
        cd <= 1'b1;
        wait_out("rdy act", 6, 1'b1, TK + 3);
        vin <= 1'b1;
        // Request while supply valid is held, taken on removal
        req <= 1'b1;
        idle(40);
        chk("ship vin", 1'b0, ship);
        vin <= 1'b0;
        wait_out("ship entry", 0, 1'b1, 20);
        // Low battery ignores button
        bat <= 1'b0;
        hold_btn(wake_ms * TK + 40);
        idle(20);
        chk("ship lowbat", 1'b1, ship);
        bat <= 1'b1;
        // Short press powers mid node but does not wake
        press <= 1'b1;
        wait_out("mid press", 1, 1'b1, 4);
        idle(wake_ms * TK / 2);
        press <= 1'b0;
        idle(20);
        chk("ship short", 1'b1, ship);
        // Full press then release wakes
        req <= 1'b0;
        hold_btn(wake_ms * TK + 8);
        wait_out("ship wake", 0, 1'b0, 10);
        // Cleared request cancels pending entry
        vin <= 1'b1;
        req <= 1'b1;
        idle(20);
        req <= 1'b0;
        idle(2);
        vin <= 1'b0;
        idle(40);
        chk("ship cancel", 1'b0, ship);
        // Charge pin low blocks entry
        cd <= 1'b0;
        req <= 1'b1;
        idle(40);
        chk("ship cd", 1'b0, ship);
        cd <= 1'b1;
        wait_out("ship cd hi", 0, 1'b1, 20);
        // Adapter above battery wakes
        req <= 1'b0;
        vin <= 1'b1;
        vab <= 1'b1;
        wait_out("ship adapter", 0, 1'b0, 10);
        // Switching output start window
        swe <= 1'b1;
        idle(10);
        chk("sw early", 1'b0, sw);
        wait_out("sw start", 5, 1'b1, 100);
        // Busy with no activity trips the idle reset
        busy <= 1'b1;
        xfer <= 1'b1;
        idle(1);
        xfer <= 1'b0;
        pulse_in("idle rst", 5 * TK + 10, 1'b1);
        busy <= 1'b0;
        // Random traffic keeps the watchdog quiet
        for (int k = 0; k < 200; k++) begin
            xfer <= ($urandom % 4 == 0);
            pulse_in("no wdog", 1, 1'b0);
        end
        xfer <= 1'b0;
        pulse_in("wdog quiet", 100, 1'b0);
        pulse_in("wdog fire", 100, 1'b1);
        // Long press with the action select low enters ship on release
        lps <= 1'b0;
        vin <= 1'b0;
        vab <= 1'b0;
        press <= 1'b1;
        idle(5000 * TK - 1000);
        chk("rout early", 1'b0, rout);
        wait_out("rout hold", 2, 1'b1, 1100);
        press <= 1'b0;
        wait_out("ship long", 0, 1'b1, 20);
        // Adapter exit, then a reset press with the action select high
        lps <= 1'b1;
        vin <= 1'b1;
        vab <= 1'b1;
        wait_out("ship adapter 2", 0, 1'b0, 10);
        press <= 1'b1;
        wait_out("rout hold 2", 2, 1'b1, 5000 * TK + 100);
        // Adapter plugged during the reset press arms a later entry
        vin <= 1'b0;
        vab <= 1'b0;
        idle(2);
        vin <= 1'b1;
        idle(2);
        press <= 1'b0;
        idle(4);
        chk("ship armed", 1'b0, ship);
        vin <= 1'b0;
        wait_out("ship arm", 0, 1'b1, 20);
        // Zero hold gives a fast reset; the button model lags one cycle
        rst_ms <= 17'h00000;
        idle(2);
        press <= 1'b1;
        wait_out("rout fast", 2, 1'b1, RST_DD_CYC + 2);
        press <= 1'b0;
        idle(4);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
